/* core/tasc_pkg.sv */
// constants, states and carriers of the alert / standby / sensor-fault controller
package tasc_pkg;
  // ----------------------------------------------------------------
  // bus addresses and register map
  // ----------------------------------------------------------------
  localparam logic [6:0] ARA_ADDR       = 7'h0C;
  localparam logic [7:0] ONESHOT_PTR    = 8'h0F;
  localparam logic [7:0] CFG_WR_PTR     = 8'h09;
  localparam int         CFG_SLEEP_PIN_N_BIT   = 6;
  localparam int         STAT_OPEN_BIT  = 2;
  localparam logic [7:0] CFG_RST        = 8'h00;
  localparam logic [7:0] STAT_RST       = 8'h00;
  localparam logic [6:0] DEV_ADDR_RST   = 7'h00;
  localparam logic [3:0] BYTE_BITS      = 4'h8;
  localparam logic [3:0] CNT_RST        = 4'h0;
  localparam logic [3:0] CNT_ONE        = 4'h1;
  localparam logic [3:0] FLAGS_RST      = 4'h0;
  // ----------------------------------------------------------------
  // states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    BUS_IDLE = 3'h0,
    BUS_ADDR = 3'h1,
    BUS_ACKA = 3'h3,
    BUS_WR   = 3'h2,
    BUS_ACKW = 3'h6,
    BUS_RD   = 3'h7,
    BUS_RACK = 3'h5
  } tasc_bus_e;
  typedef enum logic {
    CONV_IDLE = 1'b0,
    CONV_RUN  = 1'b1
  } tasc_conv_e;
  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic signed [7:0] localHigh;
    logic signed [7:0] localLow;
    logic signed [7:0] remoteHigh;
    logic signed [7:0] remoteLow;
  } tasc_limits_s;
  typedef struct packed {
    logic signed [7:0] localTemp;
    logic signed [7:0] remoteTemp;
  } tasc_meas_s;
endpackage : tasc_pkg

/* core/tasc_ctrl.sv */
// alert, standby, one-shot and open-diode control with its serial bus slave
`timescale 1ns/1ps
// How it works
// [RL1] the alert pin is pulled low for any limit violation or an open remote diode.
// [RL2] the alert pin only pulls low or floats, so several can share one wired-AND line.
// [RL3] the master reads the alert response address while the shared line is low.
// [RL4] while alerting, the block acknowledges the alert response read and returns its address.
// [RL5] bus arbitration on the returned address lets the lowest address win.
// [RL6] after answering, the alert is released only if its cause is gone.
// [RL7] the master repeats the alert response read until the shared line goes high.
// [RL8] standby is entered when the sleep pin is low or config bit 6 is set.
// [RL9] entering standby aborts a running conversion with no value write.
// [RL10] the bus slave keeps working in both standby forms.
// [RL11] with the sleep pin low no conversion starts, one-shot included.
// [RL12] in software standby any write to 0x0F runs one conversion of both channels.
// [RL13] after the one-shot the block is back in standby and the written byte is dropped.
// [RL14] each conversion start samples the open-diode comparator into status bit 2.
// [RL15] high violation is strictly above the high limit, low strictly below the low limit.
// [RL16] the host writes 0x80 to the remote low limit when that channel is unused.
// [RL17] the alert stays low until it was answered and its cause has cleared.
module tasc_ctrl
  import tasc_pkg::*;
(
  // clock and reset
  input  wire logic         clk,
  input  wire logic         nrst,
  // serial bus pins, open drain
  input  wire logic         sclIn,
  input  wire logic         sdaIn,
  output logic              sdaOut,
  output logic              sdaOeN,
  // alert pin, open drain
  output logic              alertOut,
  output logic              alertOeN,
  // straps, sleep pin and open-diode comparator
  input  wire logic [6:0]   devAddr,
  input  wire logic         sleepPinN,
  input  wire logic         diodeOpen,
  // conversion engine
  input  wire logic         convTick,
  input  wire logic         convDone,
  input  wire tasc_meas_s   meas,
  input  wire tasc_limits_s limits,
  output logic              convStart,
  output logic              convAbort,
  output logic              valueWrite,
  // register file side
  input  wire logic [7:0]   readData,
  output logic [7:0]        regPtr,
  output logic [7:0]        status,
  output logic              standby
);
  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic sclS1, sclS2, sclS3, sdaS1, sdaS2, sdaS3;
  logic sleepS1, sleepS2, diodeS1, diodeS2;
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      {sclS1, sclS2, sclS3} <= 3'h7;
      {sdaS1, sdaS2, sdaS3} <= 3'h7;
      {sleepS1, sleepS2}    <= 2'h3;
      {diodeS1, diodeS2}    <= 2'h0;
    end
    else
    begin
      {sclS1, sclS2, sclS3} <= {sclIn, sclS1, sclS2};
      {sdaS1, sdaS2, sdaS3} <= {sdaIn, sdaS1, sdaS2};
      {sleepS1, sleepS2}    <= {sleepPinN, sleepS1};
      {diodeS1, diodeS2}    <= {diodeOpen, diodeS1};
    end
  end
  // strap caught once after release of reset
  logic [6:0] devAddr_q;
  logic       strapTaken_q;
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      devAddr_q    <= DEV_ADDR_RST;
      strapTaken_q <= 1'b0;
    end
    else if (!strapTaken_q)
    begin
      devAddr_q    <= devAddr;
      strapTaken_q <= 1'b1;
    end
  end
  // ----------------------------------------------------------------
  // bus slave, alive in every standby form
  // ----------------------------------------------------------------
  tasc_bus_e  busSt_q, busSt_d;
  logic [3:0] bitCnt_q;
  logic [7:0] shift_q, tx_q, regPtr_q, cfg_q;
  logic       rw_q, araSel_q, first_q, sdaDrive_q;
  logic       alarm_q;
  wire sclRise   = sclS2 & ~sclS3;
  wire sclFall   = ~sclS2 & sclS3;
  wire startCond = sclS2 & sclS3 & sdaS3 & ~sdaS2;
  wire stopCond  = sclS2 & sclS3 & ~sdaS3 & sdaS2;
  wire byteDone  = (bitCnt_q == BYTE_BITS);
  wire hitMe     = (shift_q[7:1] == devAddr_q);
  wire hitAra    = (shift_q[7:1] == ARA_ADDR) & shift_q[0] & alarm_q; // [RL4]
  wire addrEnd   = (busSt_q == BUS_ADDR) & sclFall & byteDone;
  wire ackaEnd   = (busSt_q == BUS_ACKA) & sclFall;
  wire wrEnd     = (busSt_q == BUS_WR) & sclFall & byteDone;
  wire ackwEnd   = (busSt_q == BUS_ACKW) & sclFall;
  wire rdShift   = (busSt_q == BUS_RD) & sclFall & ~byteDone;
  wire rdEnd     = (busSt_q == BUS_RD) & sclFall & byteDone;
  wire shiftIn   = sclRise & ((busSt_q == BUS_ADDR) | (busSt_q == BUS_WR));
  wire bitCount  = sclRise & ~byteDone & ((busSt_q == BUS_ADDR) | (busSt_q == BUS_WR)
                   | (busSt_q == BUS_RD));
  // released a one but line reads zero: a lower address won
  wire lostArb   = (busSt_q == BUS_RD) & sclRise & ~sdaDrive_q & ~sdaS2; // [RL5]
  wire araDone   = (busSt_q == BUS_RACK) & sclRise & araSel_q;
  wire dataWrite = wrEnd & ~first_q;
  wire [7:0] txLoad = araSel_q ? {devAddr_q, 1'b0} : readData; // [RL4]
  always_comb
  begin
    busSt_d = busSt_q;
    if (stopCond)
      busSt_d = BUS_IDLE;
    else if (startCond)
      busSt_d = BUS_ADDR;
    else
      unique case (busSt_q)
        BUS_IDLE: busSt_d = BUS_IDLE;
        BUS_ADDR: if (addrEnd) busSt_d = (hitMe | hitAra) ? BUS_ACKA : BUS_IDLE;
        BUS_ACKA: if (ackaEnd) busSt_d = rw_q ? BUS_RD : BUS_WR;
        BUS_WR:   if (wrEnd) busSt_d = BUS_ACKW;
        BUS_ACKW: if (ackwEnd) busSt_d = BUS_WR;
        BUS_RD:   if (lostArb) busSt_d = BUS_IDLE;
                  else if (rdEnd) busSt_d = BUS_RACK;
        BUS_RACK: if (sclRise) busSt_d = BUS_IDLE;
        default:  busSt_d = BUS_IDLE;
      endcase
  end
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      busSt_q    <= BUS_IDLE;
      bitCnt_q   <= CNT_RST;
      shift_q    <= 8'h00;
      tx_q       <= 8'h00;
      rw_q       <= 1'b0;
      araSel_q   <= 1'b0;
      first_q    <= 1'b1;
      sdaDrive_q <= 1'b0;
    end
    else
    begin
      busSt_q <= busSt_d; // [RL10]
      if (startCond | ackaEnd | ackwEnd)
        bitCnt_q <= CNT_RST;
      else if (bitCount)
        bitCnt_q <= bitCnt_q + CNT_ONE;
      if (shiftIn)
        shift_q <= {shift_q[6:0], sdaS2};
      if (addrEnd)
      begin
        rw_q     <= shift_q[0];
        araSel_q <= hitAra & ~hitMe;
      end
      if (startCond)
        first_q <= 1'b1;
      else if (ackwEnd)
        first_q <= 1'b0;
      if (ackaEnd & rw_q)
        tx_q <= txLoad;
      else if (rdShift)
        tx_q <= {tx_q[6:0], 1'b0};
      if (startCond | stopCond | lostArb | rdEnd | ackwEnd | (ackaEnd & ~rw_q))
        sdaDrive_q <= 1'b0;
      else if ((addrEnd & (hitMe | hitAra)) | wrEnd)
        sdaDrive_q <= 1'b1;
      else if (ackaEnd & rw_q)
        sdaDrive_q <= ~txLoad[7];
      else if (rdShift)
        sdaDrive_q <= ~tx_q[6];
    end
  end
  // pointer and configuration writes; one-shot data is never stored
  wire oneShotWr = dataWrite & (regPtr_q == ONESHOT_PTR); // [RL13]
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      regPtr_q <= 8'h00;
      cfg_q    <= CFG_RST;
    end
    else
    begin
      if (wrEnd & first_q)
        regPtr_q <= shift_q;
      if (dataWrite & (regPtr_q == CFG_WR_PTR))
        cfg_q <= shift_q;
    end
  end
  assign sdaOut = 1'b0;
  assign sdaOeN = ~sdaDrive_q;
  assign regPtr = regPtr_q;
  // ----------------------------------------------------------------
  // standby and conversion sequencing
  // ----------------------------------------------------------------
  tasc_conv_e convSt_q;
  logic       oneShotPend_q, oneShotRun_q, convStart_q, convAbort_q, valueWrite_q;
  wire hwStandby = ~sleepS2;
  wire swStandby = cfg_q[CFG_SLEEP_PIN_N_BIT];
  wire inStandby = hwStandby | swStandby; // [RL8]
  // one-shot only honoured in software standby with the pin high
  wire oneShotReq = oneShotWr & swStandby & ~hwStandby; // [RL12]
  wire running    = (convSt_q == CONV_RUN);
  wire abortNow   = running & (hwStandby | (swStandby & ~oneShotRun_q)); // [RL9]
  wire startNow   = ~running & ~hwStandby
                    & ((convTick & ~swStandby) | oneShotPend_q); // [RL11]
  wire finishNow  = running & convDone & ~abortNow;
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      convSt_q      <= CONV_IDLE;
      oneShotPend_q <= 1'b0;
      oneShotRun_q  <= 1'b0;
      convStart_q   <= 1'b0;
      convAbort_q   <= 1'b0;
      valueWrite_q  <= 1'b0;
    end
    else
    begin
      convStart_q  <= startNow;
      convAbort_q  <= abortNow;
      valueWrite_q <= finishNow; // [RL9]
      if (startNow)
        convSt_q <= CONV_RUN;
      else if (abortNow | finishNow)
        convSt_q <= CONV_IDLE;
      // request set wins over the clear by its own start
      if (oneShotReq)
        oneShotPend_q <= 1'b1;
      else if (startNow | hwStandby)
        oneShotPend_q <= 1'b0;
      if (startNow)
        oneShotRun_q <= oneShotPend_q; // [RL13]
      else if (abortNow | finishNow)
        oneShotRun_q <= 1'b0;
    end
  end
  assign convStart  = convStart_q;
  assign convAbort  = convAbort_q;
  assign valueWrite = valueWrite_q;
  assign standby    = inStandby;
  // ----------------------------------------------------------------
  // limit compare, open-diode status and alert latch
  // ----------------------------------------------------------------
  logic [3:0] flags_q;
  logic       openFault_q;
  wire [3:0] flagsNew = {meas.localTemp  > limits.localHigh,
                         meas.localTemp  < limits.localLow,
                         meas.remoteTemp > limits.remoteHigh,
                         meas.remoteTemp < limits.remoteLow}; // [RL15]
  wire alarmCond = (|flags_q) | openFault_q; // [RL1]
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      flags_q     <= FLAGS_RST;
      openFault_q <= 1'b0;
      alarm_q     <= 1'b0;
    end
    else
    begin
      if (finishNow)
        flags_q <= flagsNew;
      if (startNow)
        openFault_q <= diodeS2; // [RL14]
      // a standing cause always wins over the answered release
      if (alarmCond)
        alarm_q <= 1'b1; // [RL1]
      else if (araDone)
        alarm_q <= 1'b0; // [RL6] [RL17]
    end
  end
  assign status   = STAT_RST | ({7'h00, openFault_q} << STAT_OPEN_BIT);
  // only ever pulls low; high level comes from the shared pull-up
  assign alertOut = 1'b0; // [RL2]
  assign alertOeN = ~alarm_q; // [RL2]
  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  alert_raise_a: assert property (@(posedge clk) disable iff (!nrst) // [RL1]
    alarmCond |=> !alertOeN) else $error("alert not raised for a standing cause");
  alert_fall_a: assert property (@(posedge clk) disable iff (!nrst) // [RL2]
    $fell(alertOeN) |-> $past(alarmCond) && alertOut == 1'b0)
    else $error("alert pulled without cause");
  ara_ack_a: assert property (@(posedge clk) disable iff (!nrst) // [RL4]
    (busSt_q == BUS_ACKA && araSel_q) |-> alarm_q && sdaDrive_q)
    else $error("alert response acked while not alerting");
  arb_lost_a: assert property (@(posedge clk) disable iff (!nrst) // [RL5]
    lostArb |=> busSt_q == BUS_IDLE && !sdaDrive_q)
    else $error("bus not released after lost arbitration");
  alert_rel_a: assert property (@(posedge clk) disable iff (!nrst) // [RL6]
    $rose(alertOeN) |-> $past(araDone) && !$past(alarmCond))
    else $error("alert released without answer or with cause");
  abort_conv_a: assert property (@(posedge clk) disable iff (!nrst) // [RL9]
    (running && hwStandby) |=> !running ##1 !valueWrite)
    else $error("conversion not aborted on standby");
  sleep_noconv_a: assert property (@(posedge clk) disable iff (!nrst) // [RL11]
    $past(hwStandby) |-> !convStart)
    else $error("conversion started while sleep pin low");
  oneshot_run_a: assert property (@(posedge clk) disable iff (!nrst) // [RL12]
    (oneShotReq && !running && !hwStandby) |-> ##[1:2] convStart)
    else $error("one-shot write did not start a conversion");
  fault_samp_a: assert property (@(posedge clk) disable iff (!nrst) // [RL14]
    (startNow && diodeS2) |=> status[STAT_OPEN_BIT])
    else $error("open diode not flagged at conversion start");
  high_cmp_a: assert property (@(posedge clk) disable iff (!nrst) // [RL15]
    (finishNow && meas.localTemp == limits.localHigh) |=> !flags_q[3])
    else $error("high limit equal reading flagged");
endmodule : tasc_ctrl

/* bench/tasc_bus_master.sv */
// serial bus master model that services the shared alert line
`timescale 1ns/1ps
module tasc_bus_master
  import tasc_pkg::*;
(
  // bus pins, open drain, released level is the pull-up
  output logic      scl,
  output logic      sdaDrv,
  input  wire logic sdaIn
);
  // quarter of the 160 ns bus clock; low phase lasts four core clocks
  localparam time QTR = 40ns;
  initial
  begin
    scl    = 1'b1;
    sdaDrv = 1'b1;
  end
  // ----------------------------------------------------------------
  // framing and bit cycles; clock stands high between frames
  // ----------------------------------------------------------------
  task automatic frameStart;
    #1; // step off the core clock edge so the pins never race its flops
    sdaDrv = 1'b1;
    #QTR scl = 1'b1;
    #QTR sdaDrv = 1'b0;
    #QTR scl = 1'b0;
    #QTR;
  endtask : frameStart
  task automatic frameStop;
    sdaDrv = 1'b0;
    #QTR scl = 1'b1;
    #QTR sdaDrv = 1'b1;
    #(2 * QTR);
  endtask : frameStop
  task automatic sendBit(input logic b);
    sdaDrv = b;
    #QTR scl = 1'b1;
    #(2 * QTR) scl = 1'b0;
    #QTR;
  endtask : sendBit
  // drive o like any device on the line, read back the wired-AND level
  task automatic xchgBit(input logic o, output logic b);
    sdaDrv = o;
    #QTR scl = 1'b1;
    #QTR b = sdaIn; // wired-AND read, lowest address wins
    #QTR scl = 1'b0;
    #QTR;
  endtask : xchgBit
  task automatic recvBit(output logic b);
    xchgBit(1'b1, b);
  endtask : recvBit
  task automatic txByte(input logic [7:0] d, output logic ack);
    for (int i = 7; i >= 0; i--)
      sendBit(d[i]);
    recvBit(ack);
  endtask : txByte
  task automatic rxByte(output logic [7:0] d, input logic last);
    for (int i = 7; i >= 0; i--)
      recvBit(d[i]);
    sendBit(last);
  endtask : rxByte
  // single byte read, then no-ack
  task automatic readByte(input logic [6:0] addr, output logic ack, output logic [7:0] d);
    frameStart();
    txByte({addr, 1'b1}, ack);
    d = 8'hFF;
    if (ack == 1'b0)
      rxByte(d, 1'b1);
    frameStop();
  endtask : readByte
  // read from the alert response address
  task automatic ara(output logic ack, output logic [7:0] d);
    readByte(ARA_ADDR, ack, d);
  endtask : ara
  // alert response read with a second alerting device answering rival
  task automatic araRival(input logic [7:0] rival, output logic [7:0] d);
    logic ack;
    frameStart();
    txByte({ARA_ADDR, 1'b1}, ack);
    for (int i = 7; i >= 0; i--)
      xchgBit(rival[i], d[i]);
    sendBit(1'b1);
    frameStop();
  endtask : araRival
endmodule : tasc_bus_master

/* bench/thermal_alert_standby_ctrl_tb.sv */
// self-checking bench of the alert, standby and open-diode controller
`timescale 1ns/1ps
module thermal_alert_standby_ctrl_tb
  import tasc_pkg::*;
;
  localparam logic [6:0] DEV = 7'h29;
  localparam logic [7:0] RDV = 8'h5A; // register file data seen by every plain read
  logic         clk        = 1'b0;
  logic         nrst       = 1'b0;
  logic         sleepPinN  = 1'b1;
  logic         diodeOpen  = 1'b0;
  logic         convTick   = 1'b0;
  logic         convDone   = 1'b0;
  tasc_meas_s   meas       = 16'h1919;
  tasc_limits_s lim        = 32'h3280_7F80; // remote low at 0x80, unused channel
  logic         scl, sdaDrv, sdaOut, sdaOeN, alertOut, alertOeN;
  logic         convStart, convAbort, valueWrite, standby;
  logic [7:0]   regPtr, status;
  logic [7:0]   nStart     = 8'h00;
  logic [7:0]   nAbort     = 8'h00;
  logic [7:0]   nWrite     = 8'h00;
  int           miscompares  = 0;
  int           total_checks = 0;
  wire          sdaWire    = sdaDrv & sdaOeN;
  wire          alertWire  = alertOeN; // only this device shares the line
  always #10 clk = ~clk;
  tasc_bus_master M (.scl(scl), .sdaDrv(sdaDrv), .sdaIn(sdaWire));
  tasc_ctrl DUT (
    .clk(clk), .nrst(nrst), .sclIn(scl), .sdaIn(sdaWire), .sdaOut(sdaOut), .sdaOeN(sdaOeN),
    .alertOut(alertOut), .alertOeN(alertOeN), .devAddr(DEV), .sleepPinN(sleepPinN),
    .diodeOpen(diodeOpen), .convTick(convTick), .convDone(convDone), .meas(meas),
    .limits(lim), .convStart(convStart), .convAbort(convAbort), .valueWrite(valueWrite),
    .readData(RDV), .regPtr(regPtr), .status(status), .standby(standby));
  // pulse counters; a lost or doubled pulse shows as a count error
  always @(posedge clk)
  begin
    nStart <= nStart + {7'h00, convStart};
    nAbort <= nAbort + {7'h00, convAbort};
    nWrite <= nWrite + {7'h00, valueWrite};
  end
  // ----------------------------------------------------------------
  // compare and drive helpers
  // ----------------------------------------------------------------
  task automatic chkByte(input logic [7:0] got, input logic [7:0] exp, input string what);
    total_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chkByte
  task automatic chkBit(input logic got, input logic exp, input string what);
    chkByte({7'h00, got}, {7'h00, exp}, what);
  endtask : chkBit
  task automatic tick;
    @(posedge clk) convTick <= 1'b1;
    @(posedge clk) convTick <= 1'b0;
  endtask : tick
  task automatic conv(input logic [7:0] lt, input logic [7:0] rt);
    tick();
    repeat (3) @(posedge clk);
    convDone <= 1'b1;
    meas     <= {lt, rt};
    @(posedge clk) convDone <= 1'b0;
    repeat (4) @(posedge clk);
  endtask : conv
  task automatic regWrite(input logic [7:0] ptr, input logic [7:0] d);
    logic a0, a1, a2;
    M.frameStart();
    M.txByte({DEV, 1'b0}, a0);
    M.txByte(ptr, a1);
    M.txByte(d, a2);
    M.frameStop();
    chkByte({5'h00, a0, a1, a2}, 8'h00, "write acks");
    repeat (8) @(posedge clk);
  endtask : regWrite
  task automatic clearAlert;
    logic       a;
    logic [7:0] d;
    conv(8'h19, 8'h19);
    for (int i = 0; i < 4 && alertWire == 1'b0; i++)
      M.ara(a, d);
    repeat (8) @(posedge clk);
    chkBit(alertWire, 1'b1, "alert cleared");
  endtask : clearAlert
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    chkBit(alertOeN, 1'b1, "alert idle");
    chkByte({6'h00, alertOut, sdaOut}, 8'h00, "pins never high");
    chkBit(standby, 1'b0, "standby idle");
    chkByte(status, STAT_RST, "status reset");
    $display("test reset done");
  endtask : t_reset
  task automatic t_limits;
    conv(8'h32, 8'h80);
    chkBit(alertOeN, 1'b1, "equal limits");
    lim.remoteLow <= 8'h81;
    conv(8'h19, 8'h80);
    chkBit(alertOeN, 1'b0, "below low");
    lim.remoteLow <= 8'h80;
    clearAlert();
    conv(8'h33, 8'h19);
    chkBit(alertOeN, 1'b0, "above high");
    $display("test limits done");
  endtask : t_limits
  task automatic t_ara;
    logic       a;
    logic [7:0] d;
    M.araRival(8'h30, d);
    chkByte(d, 8'h30, "lower address wins");
    chkBit(alertOeN, 1'b0, "loser keeps alert");
    M.ara(a, d);
    chkBit(a, 1'b0, "ara ack");
    chkByte(d, {DEV, 1'b0}, "ara data");
    repeat (8) @(posedge clk);
    chkBit(alertOeN, 1'b0, "cause remains");
    conv(8'h19, 8'h19);
    chkBit(alertOeN, 1'b0, "held until answered");
    M.ara(a, d);
    repeat (8) @(posedge clk);
    chkBit(alertOeN, 1'b1, "released");
    M.ara(a, d);
    chkBit(a, 1'b1, "silent when quiet");
    $display("test ara done");
  endtask : t_ara
  task automatic t_open;
    diodeOpen <= 1'b1;
    repeat (4) @(posedge clk);
    conv(8'h19, 8'h19);
    chkBit(status[STAT_OPEN_BIT], 1'b1, "open flag");
    chkBit(alertOeN, 1'b0, "open alert");
    diodeOpen <= 1'b0;
    repeat (4) @(posedge clk);
    clearAlert();
    chkBit(status[STAT_OPEN_BIT], 1'b0, "open flag gone");
    $display("test open diode done");
  endtask : t_open
  task automatic t_sleep;
    logic [7:0] st, ab, wr, d;
    logic       a;
    tick();
    repeat (2) @(posedge clk);
    {st, ab, wr} = {nStart, nAbort, nWrite};
    sleepPinN <= 1'b0;
    repeat (6) @(posedge clk);
    chkBit(standby, 1'b1, "pin standby");
    chkByte(nAbort, ab + 8'h01, "abort pulse");
    tick();
    regWrite(ONESHOT_PTR, 8'hA5);
    chkByte(regPtr, ONESHOT_PTR, "pointer in standby");
    M.readByte(DEV, a, d);
    chkBit(a, 1'b0, "read ack in standby");
    chkByte(d, RDV, "read data in standby");
    repeat (10) @(posedge clk);
    chkByte(nStart, st, "no start");
    chkByte(nWrite, wr, "no value write");
    sleepPinN <= 1'b1;
    repeat (6) @(posedge clk);
    chkBit(standby, 1'b0, "awake");
    $display("test sleep pin done");
  endtask : t_sleep
  task automatic t_swstby;
    logic [7:0] st, wr, ab;
    ab = nAbort;
    tick();
    regWrite(CFG_WR_PTR, 8'h40);
    chkByte(nAbort, ab + 8'h01, "soft abort");
    chkBit(standby, 1'b1, "soft standby");
    {st, wr} = {nStart, nWrite};
    tick();
    repeat (4) @(posedge clk);
    chkByte(nStart, st, "tick refused");
    regWrite(ONESHOT_PTR, 8'hA5);
    chkByte(nStart, st + 8'h01, "one-shot start");
    conv(8'h19, 8'h19);
    chkByte(nWrite, wr + 8'h01, "one-shot result");
    chkByte(nStart, st + 8'h01, "single run");
    chkBit(standby, 1'b1, "back in standby");
    regWrite(CFG_WR_PTR, 8'h00);
    chkBit(standby, 1'b0, "soft wake");
    $display("test soft standby done");
  endtask : t_swstby
  task automatic test_done;
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : test_done
  initial
  begin
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    repeat (10) @(posedge clk);
    t_reset();
    t_limits();
    t_ara();
    t_open();
    t_sleep();
    t_swstby();
    test_done();
  end
  // run needs under 150 us; a hang is cut well after that
  initial
  begin
    #600us;
    miscompares++;
    $display("ERROR %0t watchdog expired", $time);
    test_done();
  end
endmodule : thermal_alert_standby_ctrl_tb
